// ===== gain_ctrl_pkg.sv
/*
 * package for the receiver gain control block: register map, field
 * positions, reset values, timing counts and carrier structs.
 * assumes a 100 MHz aclk and a 32-bit axi4-lite register bus.
 */
package gain_ctrl_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SQ_WIN_US = 50;
    localparam int SQ_WIN_CYC = SQ_WIN_US * CLK_MHZ;
    localparam int SQ_DELAY_NS = 18880;
    localparam int SQ_DELAY_CYC = (SQ_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int SQ_MAX_TRANS = 2;
    localparam int AGC_FAST_PULSES = 8;

    // ----------------------------------------------------------------
    // gain state codes
    // ----------------------------------------------------------------
    localparam logic [3:0] STATE_MIN = 4'h0;
    localparam logic [3:0] STATE_PRESET = 4'h4;
    localparam logic [3:0] STATE_LAST = 4'ha;
    localparam logic [3:0] STRENGTH_MAX = 4'hd;
    localparam logic [2:0] FORCE_STAGE_RED = 3'h2;
    localparam logic [2:0] WINDOW_MAX = 3'h4;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_RX_CONF2 = 8'h00;
    localparam logic [7:0] OFS_RX_CONF3 = 8'h04;
    localparam logic [7:0] OFS_RX_CONF4 = 8'h08;
    localparam logic [7:0] OFS_COMMAND = 8'h0c;
    localparam logic [7:0] OFS_GAIN_STATE = 8'h10;
    localparam logic [7:0] OFS_STRENGTH = 8'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_SQ_DYN = 0;
    localparam int BIT_AGC_EN = 1;
    localparam int BIT_AGC_MODE = 2;
    localparam int BIT_AGC_ALG = 3;
    localparam int BIT_CLIP_EN = 0;
    localparam int BIT_FORCE = 1;
    localparam int BIT_CMD_CLR_GAIN = 0;
    localparam int BIT_CMD_SQUELCH = 1;
    localparam int BIT_CMD_CLR_STR = 2;
    localparam int BIT_CMD_PRESET = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] RST_RX_CONF2 = 4'h2;
    localparam logic [1:0] RST_RX_CONF3 = 2'h0;
    localparam logic [3:0] RST_RX_CONF4 = 4'h0;
    localparam logic [3:0] PRESET_RX_CONF2 = 4'h2;
    localparam logic [1:0] PRESET_RX_CONF3 = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic digitizer_out;
        logic agc_cmp_out;
        logic subcarrier_pulse;
        logic [3:0] strength_am;
        logic [3:0] strength_pm;
    } analog_in_t;

    typedef struct packed {
        logic [2:0] window_sel;
        logic [2:0] stage_red;
        logic clip_en;
    } analog_out_t;

    typedef struct packed {
        logic clr_gain;
        logic squelch;
        logic clr_strength;
        logic preset;
    } cmd_t;

endpackage

// ===== peak_hold.sv
/*
 * peak hold of one 4-bit strength channel.
 * assumes the sampled code is synchronous to aclk.
 */
`timescale 1ns/1ps
module peak_hold
    import gain_ctrl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic restart,
    input wire logic track,
    input wire logic [3:0] sample,
    // result
    output logic [3:0] peak
);
    logic [3:0] peak_reg;
    logic [3:0] clipped;
    logic [3:0] peak_next;

    assign clipped = (sample > STRENGTH_MAX) ? STRENGTH_MAX : sample;
    assign peak_next = restart ? 4'h0 :
                       (track && clipped > peak_reg) ? clipped : peak_reg;
    assign peak = peak_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peak_reg <= 4'h0;
        end else begin
            peak_reg <= peak_next;
        end
    end
endmodule

// ===== receiver_gain_control.sv
/*
 * receiver gain control: squelch, agc, strength peak hold, peer-mode
 * clip and force options, with an axi4-lite register slave.
 * assumes all analog inputs and rx_window are synchronous to aclk.
 */
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module receiver_gain_control
    import gain_ctrl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // receive framing status
    input wire logic rx_window,
    input wire logic tx_end,
    input wire logic mask_timer_expired,
    // analog chain
    input wire analog_in_t ana_in,
    output analog_out_t ana_out
);

    // ----------------------------------------------------------------
    // registers and bus state
    // ----------------------------------------------------------------
    logic [3:0] conf2_reg;
    logic [1:0] conf3_reg;
    logic [3:0] conf4_reg;
    logic [3:0] gain_state_reg;
    logic [3:0] state_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == OFS_RX_CONF2) || (a == OFS_RX_CONF3) || (a == OFS_RX_CONF4) ||
                     (a == OFS_COMMAND) || (a == OFS_GAIN_STATE) || (a == OFS_STRENGTH);
    endfunction

    // ----------------------------------------------------------------
    // write channel: address and data taken in either order
    // ----------------------------------------------------------------
    wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_lane0 = wr_fire && w_strb_reg[0];
    wire wr_conf2 = wr_lane0 && aw_addr_reg == OFS_RX_CONF2;
    wire wr_conf3 = wr_lane0 && aw_addr_reg == OFS_RX_CONF3;
    wire wr_conf4 = wr_lane0 && aw_addr_reg == OFS_RX_CONF4;
    wire wr_cmd = wr_lane0 && aw_addr_reg == OFS_COMMAND;

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // commands: one-cycle pulses from the command register
    // ----------------------------------------------------------------
    cmd_t cmd;
    assign cmd.clr_gain = wr_cmd && w_data_reg[BIT_CMD_CLR_GAIN];
    assign cmd.squelch = wr_cmd && w_data_reg[BIT_CMD_SQUELCH] && !rx_window;
    assign cmd.clr_strength = wr_cmd && w_data_reg[BIT_CMD_CLR_STR];
    assign cmd.preset = wr_cmd && w_data_reg[BIT_CMD_PRESET];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conf2_reg <= RST_RX_CONF2;
            conf3_reg <= RST_RX_CONF3;
            conf4_reg <= RST_RX_CONF4;
        end else if (cmd.preset) begin
            conf2_reg <= PRESET_RX_CONF2;
            conf3_reg <= PRESET_RX_CONF3;
        end else begin
            if (wr_conf2) conf2_reg <= w_data_reg[3:0];
            if (wr_conf3) conf3_reg <= w_data_reg[1:0];
            if (wr_conf4) conf4_reg <= w_data_reg[3:0];
        end
    end

    wire sq_dyn = conf2_reg[BIT_SQ_DYN];
    wire agc_en = conf2_reg[BIT_AGC_EN];
    wire agc_first8 = conf2_reg[BIT_AGC_MODE];
    wire agc_zero_alg = conf2_reg[BIT_AGC_ALG];

    // ----------------------------------------------------------------
    // edge detection on the window and the comparators
    // ----------------------------------------------------------------
    logic rx_window_d_reg;
    logic dig_d_reg;
    logic agc_cmp_d_reg;
    logic pulse_d_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_window_d_reg <= 1'b0;
            dig_d_reg <= 1'b0;
            agc_cmp_d_reg <= 1'b0;
            pulse_d_reg <= 1'b0;
        end else begin
            rx_window_d_reg <= rx_window;
            dig_d_reg <= ana_in.digitizer_out;
            agc_cmp_d_reg <= ana_in.agc_cmp_out;
            pulse_d_reg <= ana_in.subcarrier_pulse;
        end
    end
    wire win_rise = rx_window && !rx_window_d_reg;
    wire win_fall = !rx_window && rx_window_d_reg;
    wire dig_edge = ana_in.digitizer_out ^ dig_d_reg;
    wire agc_edge = ana_in.agc_cmp_out ^ agc_cmp_d_reg;
    wire pulse_rise = ana_in.subcarrier_pulse && !pulse_d_reg;

    // ----------------------------------------------------------------
    // squelch sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_WAIT = 3'b010,
        SQ_RUN = 3'b100
    } sq_state_t;
    sq_state_t sq_reg;
    sq_state_t sq_next;
    logic [12:0] sq_timer_reg;
    logic [1:0] sq_edges_reg;
    logic sq_cmd_reg;

    wire at_last = state_reg == STATE_LAST;
    wire sq_tick = sq_timer_reg == 13'(SQ_WIN_CYC - 1);
    wire sq_noisy = sq_edges_reg > 2'(SQ_MAX_TRANS);
    wire sq_step = (sq_reg == SQ_RUN) && sq_tick && sq_noisy && !at_last;
    wire sq_done = (sq_reg == SQ_RUN) && sq_tick && (!sq_noisy || at_last);
    wire sq_abort = (sq_reg != SQ_IDLE) && !sq_cmd_reg && mask_timer_expired;

    always_comb begin
        sq_next = sq_reg;
        case (sq_reg)
            SQ_IDLE: begin
                if (cmd.squelch) begin
                    sq_next = SQ_RUN;
                end else if (tx_end && sq_dyn) begin
                    sq_next = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                if (sq_abort) sq_next = SQ_IDLE;
                else if (sq_timer_reg == 13'(SQ_DELAY_CYC - 1)) sq_next = SQ_RUN;
            end
            SQ_RUN: begin
                if (sq_abort || sq_done || cmd.clr_gain) sq_next = SQ_IDLE;
            end
            default: sq_next = SQ_IDLE;
        endcase
    end

    wire sq_timer_clear = (sq_next != sq_reg) || sq_tick;
    wire [1:0] sq_edges_next = sq_timer_clear ? 2'd0 :
                               (dig_edge && sq_edges_reg != 2'd3) ? sq_edges_reg + 2'd1 : sq_edges_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sq_reg <= SQ_IDLE;
            sq_timer_reg <= 13'd0;
            sq_edges_reg <= 2'd0;
            sq_cmd_reg <= 1'b0;
        end else begin
            sq_reg <= sq_next;
            sq_timer_reg <= sq_timer_clear ? 13'd0 : sq_timer_reg + 13'd1;
            sq_edges_reg <= (sq_reg == SQ_RUN) ? sq_edges_next : 2'd0;
            if (sq_reg == SQ_IDLE) sq_cmd_reg <= cmd.squelch;
        end
    end

    // ----------------------------------------------------------------
    // agc and the shared gain state
    // ----------------------------------------------------------------
    logic [3:0] pulse_cnt_reg;
    logic [3:0] sq_base_reg;
    wire agc_window = agc_first8 ? (pulse_cnt_reg < 4'(AGC_FAST_PULSES)) : 1'b1;
    wire agc_step = agc_en && rx_window && !win_rise && agc_window && agc_edge && !at_last;
    wire [3:0] agc_start = agc_zero_alg ? STATE_MIN : STATE_PRESET;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= RST_RX_CONF4;
            sq_base_reg <= RST_RX_CONF4;
            pulse_cnt_reg <= 4'd0;
            gain_state_reg <= 4'h0;
        end else begin
            if (!rx_window || win_rise) pulse_cnt_reg <= 4'd0;
            else if (pulse_rise && pulse_cnt_reg != 4'hf) pulse_cnt_reg <= pulse_cnt_reg + 4'd1;
            if (cmd.clr_gain) begin
                state_reg <= conf4_reg;
                sq_base_reg <= conf4_reg;
            end else if (win_rise && agc_en) begin
                state_reg <= (agc_start > sq_base_reg) ? agc_start : sq_base_reg;
            end else if (win_fall) begin
                state_reg <= sq_base_reg;
            end else if (sq_step) begin
                state_reg <= state_reg + 4'd1;
                sq_base_reg <= state_reg + 4'd1;
            end else if (agc_step) begin
                state_reg <= state_reg + 4'd1;
            end
            if (win_fall) gain_state_reg <= state_reg;
        end
    end

    // ----------------------------------------------------------------
    // state code to analog settings: window first, then stage gain
    // ----------------------------------------------------------------
    wire force_on = conf3_reg[BIT_FORCE];
    wire [2:0] win_code = (state_reg > 4'(WINDOW_MAX)) ? WINDOW_MAX : state_reg[2:0];
    wire [3:0] red_wide = (state_reg > 4'(WINDOW_MAX)) ? state_reg - 4'(WINDOW_MAX) : 4'd0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ana_out <= '0;
        end else begin
            ana_out.window_sel <= force_on ? WINDOW_MAX : win_code;
            ana_out.stage_red <= force_on ? FORCE_STAGE_RED : red_wide[2:0];
            ana_out.clip_en <= conf3_reg[BIT_CLIP_EN];
        end
    end

    // ----------------------------------------------------------------
    // strength peak hold on both channels
    // ----------------------------------------------------------------
    logic [3:0] str_am;
    logic [3:0] str_pm;
    wire str_restart = cmd.clr_strength || win_rise || agc_step;
    wire str_track = rx_window;

    peak_hold am_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(str_restart),
        .track(str_track),
        .sample(ana_in.strength_am),
        .peak(str_am)
    );
    peak_hold pm_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(str_restart),
        .track(str_track),
        .sample(ana_in.strength_pm),
        .peak(str_pm)
    );

    // ----------------------------------------------------------------
    // read channel: one read under way, answer a cycle after address
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            OFS_RX_CONF2: rd_mux = {28'h000_0000, conf2_reg};
            OFS_RX_CONF3: rd_mux = {30'h0000_0000, conf3_reg};
            OFS_RX_CONF4: rd_mux = {28'h000_0000, conf4_reg};
            OFS_GAIN_STATE: rd_mux = {28'h000_0000, gain_state_reg};
            OFS_STRENGTH: rd_mux = {24'h00_0000, str_pm, str_am};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule

// ===== rgc_analog_model.sv
/*
 * analog receiver stand-in: digitizer noise source plus pass-through of
 * the gain comparator, subcarrier and strength codes driven by the bench.
 * assumes aclk is the block clock and all outputs are aclk-synchronous.
 */
`timescale 1ns/1ps
module rgc_analog_model
    import gain_ctrl_pkg::*;
(
    // clock
    input wire logic aclk,
    // stimulus from the bench
    input wire logic noise_en,
    input wire logic cmp,
    input wire logic pulse,
    input wire logic [3:0] am,
    input wire logic [3:0] pm,
    // towards the block
    output analog_in_t ana
);
    // ----------
    // noise
    // ----------
    // one digitizer edge every 500 cycles: ten per 50 us interval
    logic [8:0] tick_reg = 9'h0;
    logic dig_reg = 1'b0;
    always @(posedge aclk) begin
        tick_reg <= (tick_reg == 9'h1f3) ? 9'h0 : tick_reg + 9'h1;
        if (noise_en && tick_reg == 9'h0) dig_reg <= !dig_reg;
    end
    assign ana = '{dig_reg, cmp, pulse, am, pm};
endmodule

// ===== receiver_gain_control_props.sv
/*
 * port-level assertions for receiver_gain_control.
 * assumes one aclk domain and the synchronous active-low aresetn.
 */
`timescale 1ns/1ps
module receiver_gain_control_props
    import gain_ctrl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // receiver
    input wire logic rx_window,
    input wire analog_out_t ana_out
);
    // ----------
    // helpers
    // ----------
    // writes may jump the state (clear gain, preset), so step checks wait them out
    logic [2:0] quiet_reg;
    wire logic [3:0] st = ana_out.window_sel + ana_out.stage_red;
    always_ff @(posedge aclk) begin
        if (!aresetn || s_axi_bvalid) begin
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------
    // properties
    // ----------
    sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_wr_answer; ##2 s_axi_bvalid; endsequence
    property p_window_max; ana_out.window_sel <= WINDOW_MAX; endproperty
    a_window_max: assert property (p_window_max) else $error("window select above maximum");
    property p_stage_max; ana_out.stage_red <= 3'h6; endproperty
    a_stage_max: assert property (p_stage_max) else $error("stage reduction past last state");
    property p_stage_order; ana_out.stage_red != 3'h0 |-> ana_out.window_sel == WINDOW_MAX; endproperty
    a_stage_order: assert property (p_stage_order) else $error("stage cut before window is widest");
    property p_squelch_step;
        !rx_window && $past(!rx_window) && $past(!rx_window, 2) && quiet_reg > 3'h4
            |-> {1'b0, st} <= {1'b0, $past(st)} + 5'h1;
    endproperty
    a_squelch_step: assert property (p_squelch_step) else $error("gain moved more than one step");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_hold; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer not retired");
    property p_wr_answer; s_wr_taken |-> s_wr_answer; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_wr_hold; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write response not retired");
endmodule
bind receiver_gain_control receiver_gain_control_props receiver_gain_control_props_inst (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_window, .ana_out);

// ===== receiver_gain_control_test.sv
/*
 * self-checking bench for receiver_gain_control with the analog stand-in.
 * assumes the hand-over latencies and the package register map.
 */
`timescale 1ns/1ps
module receiver_gain_control_test
    import gain_ctrl_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_window = 1'b0, tx_end = 1'b0;
    logic mask_timer_expired = 1'b0, noise_en = 1'b0, cmp = 1'b0, pulse = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf, am = 4'h0, pm = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    analog_in_t ana_in;
    analog_out_t ana_out;
    int bad_count = 0;
    int compares = 0;
    always #5 aclk = ~aclk;
    receiver_gain_control receiver_gain_control_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rx_window, .tx_end, .mask_timer_expired, .ana_in, .ana_out);
    rgc_analog_model rgc_analog_model_inst (.aclk, .noise_en, .cmp, .pulse, .am, .pm, .ana(ana_in));
    // ----------
    // tasks
    // ----------
    task automatic end_sim();
        $display("mismatches %0d, compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ready goes up with the request; an idle edge separates two calls
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        if (n == 200) begin
            bad_count++;
            end_sim();
        end
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        if (n == 200) begin
            bad_count++;
            end_sim();
        end
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        chk("rdata", exp, s_axi_rdata);
        cyc(1);
    endtask
    // expected window/stage pair of a combined gain state
    task automatic chk_state(input int s);
        chk("ana_out", {26'h0, 3'(s > 4 ? 4 : s), 3'(s > 4 ? s - 4 : 0)},
            {26'h0, ana_out.window_sel, ana_out.stage_red});
    endtask
    task automatic kick();
        cmp <= !cmp;
        cyc(3);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        rd(OFS_RX_CONF2, 32'h2);
        rd(OFS_STRENGTH, 32'h0);
        rd(8'h1c, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'hff, RESP_SLVERR);
        chk_state(0);
    endtask
    task automatic t_squelch();
        wr(OFS_COMMAND, 32'h1);
        wr(OFS_COMMAND, 32'h2);
        noise_en <= 1'b1;
        cyc(10000);
        noise_en <= 1'b0;
        cyc(10000);
        chk_state(2);
        rx_window <= 1'b1;
        wr(OFS_COMMAND, 32'h2);
        chk_state(4);
        rx_window <= 1'b0;
        noise_en <= 1'b1;
        cyc(6000);
        noise_en <= 1'b0;
        chk_state(2);
        wr(OFS_RX_CONF4, 32'h9);
        wr(OFS_COMMAND, 32'h1);
        chk_state(9);
        wr(OFS_COMMAND, 32'h2);
        noise_en <= 1'b1;
        cyc(15000);
        noise_en <= 1'b0;
        chk_state(10);
    endtask
    task automatic t_agc();
        wr(OFS_RX_CONF4, 32'h0);
        wr(OFS_COMMAND, 32'h1);
        wr(OFS_RX_CONF2, 32'ha);
        rx_window <= 1'b1;
        cyc(3);
        chk_state(0);
        repeat (3) kick();
        chk_state(3);
        am <= 4'h7;
        pm <= 4'h9;
        cyc(3);
        rd(OFS_STRENGTH, 32'h97);
        am <= 4'hf;
        cyc(3);
        rd(OFS_STRENGTH, 32'h9d);
        am <= 4'h2;
        kick();
        rd(OFS_STRENGTH, 32'h92);
        rx_window <= 1'b0;
        am <= 4'h5;
        cyc(3);
        rd(OFS_STRENGTH, 32'h92);
        rd(OFS_GAIN_STATE, 32'h4);
        chk_state(0);
        wr(OFS_COMMAND, 32'h4);
        rd(OFS_STRENGTH, 32'h0);
    endtask
    task automatic t_mode();
        wr(OFS_RX_CONF2, 32'he);
        rx_window <= 1'b1;
        cyc(2);
        repeat (8) begin
            pulse <= 1'b1;
            cyc(2);
            pulse <= 1'b0;
            cyc(2);
        end
        kick();
        chk_state(0);
        rx_window <= 1'b0;
        cyc(2);
    endtask
    task automatic t_dyn();
        wr(OFS_RX_CONF2, 32'h3);
        tx_end <= 1'b1;
        cyc(1);
        tx_end <= 1'b0;
        noise_en <= 1'b1;
        cyc(5500);
        chk_state(0);
        cyc(1600);
        mask_timer_expired <= 1'b1;
        cyc(1);
        mask_timer_expired <= 1'b0;
        cyc(6000);
        noise_en <= 1'b0;
        chk_state(1);
    endtask
    task automatic t_peer();
        wr(OFS_RX_CONF3, 32'h1);
        cyc(2);
        chk("clip", 32'h1, 32'(ana_out.clip_en));
        wr(OFS_COMMAND, 32'h8);
        rd(OFS_RX_CONF3, 32'h3);
        s_axi_wstrb <= 4'he;
        wr(OFS_RX_CONF3, 32'h0);
        s_axi_wstrb <= 4'hf;
        rd(OFS_RX_CONF3, 32'h3);
        cyc(2);
        chk("forced", 32'h45, {25'h0, ana_out});
    endtask
    initial begin
        cyc(5);
        aresetn <= 1'b1;
        t_reset();
        t_squelch();
        t_agc();
        t_mode();
        t_dyn();
        t_peer();
        end_sim();
    end
endmodule
